// [design/rsc_defs.svh]
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// Overview of operation
// R1: Power-on starts full sequence, holds reset
// R2: Disabled monitor forced lowest during erase/debug
// R3: Qualified low supply asserts brownout reset immediately
// R4: Recovery releases only through reset counter
// R5: Low supply must persist past detection time
// R6: Threshold code 111 lowest, 000 highest
// R7: Threshold fuse change waits for programming exit
// R8: Sampled mode powers monitor once per tick
// R9: Sampled trip switches monitor to continuous
// R10: Active fuse in active/idle, sleep otherwise
// R11: Mode codes: reserved, sampled, enabled, disabled
// R12: Pin reset held while pin stays low
// R13: Watchdog reset lasts one to two oscillator periods
// R14: Software reset issued within two clocks
// R15: Instruction execution stalled until software reset
// R16: Debug reset only from debug port
// R17: Cause flags 5..1 set by source, W1C
// R18: Power-on flag set by power-on, W1C only
// R19: Control bit 0 requests reset, self-clears
// R20: Control writes need protection gate open
// R21: Software writes zero to reserved bits
// R22: New request restarts whole sequence
// R23: Delay codes 64K, 4K ticks, plus 24 clocks
// R24: Cause flags survive non-power-on resets
// R25: Merged reset holds until all sources release

// Register indices; byte address is four times the index
`define RSC_CAUSE_IDX 8'h00
`define RSC_CTRL_IDX 8'h01
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

// Cause flag bits
`define RSC_FLAG_SOFT 5
`define RSC_FLAG_DEBUG 4
`define RSC_FLAG_WD 3
`define RSC_FLAG_BROWN 2
`define RSC_FLAG_PIN 1
`define RSC_FLAG_PON 0
`define RSC_CAUSE_RESET 6'h01
`define RSC_SOFT_BIT 0

// Monitor fuse decoding
`define RSC_MODE_RESERVED 2'h0
`define RSC_MODE_SAMPLED 2'h1
`define RSC_MODE_ENABLED 2'h2
`define RSC_MODE_DISABLED 2'h3
`define RSC_LEVEL_LOWEST 3'h7
`define RSC_LEVEL_HIGHEST 3'h0

// Reset counter delay codes
`define RSC_DELAY_LONG 2'h0
`define RSC_DELAY_SHORT 2'h1
`define RSC_DELAY_SYS_ONLY 2'h3
`define RSC_SHORT_TICKS 4096
`define RSC_LONG_TICKS 65536
`define RSC_SYS_DELAY_CYC 24

// Timing
`define RSC_MCLK_MHZ 20
`define RSC_OSC_MHZ 2
`define RSC_OSC_DIV (`RSC_MCLK_MHZ / `RSC_OSC_MHZ)
`define RSC_BOD_MIN_NS 1000
`define RSC_EXT_MIN_NS 1000
`define RSC_BOD_MIN_CYC ((`RSC_BOD_MIN_NS * `RSC_MCLK_MHZ + 999) / 1000)
`define RSC_EXT_MIN_CYC ((`RSC_EXT_MIN_NS * `RSC_MCLK_MHZ + 999) / 1000)
`define RSC_SAMPLE_WIN_CYC (`RSC_BOD_MIN_CYC + 3)
`define RSC_SYNC_CYC 5'h02
`endif

// [design/rsc_pkg.sv]
package rsc_pkg;
  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_LP_WAIT,
    SEQ_SYS_WAIT,
    SEQ_RUN
  } rsc_seq_type;

  typedef struct packed {
    logic ext_reset_b;
    logic monitor_low;
    logic lp_tick;
    logic watchdog_req;
    logic debug_reset_req;
    logic programming_mode;
    logic chip_erase;
    logic debug_enable;
    logic deep_sleep;
    logic [2:0] monitor_threshold_fuse;
    logic [1:0] monitor_active_mode_fuse;
    logic [1:0] monitor_sleep_mode_fuse;
    logic [1:0] startup_delay_fuse;
  } rsc_pins_type;

  typedef struct packed {
    rsc_pins_type sync1;
    rsc_pins_type sync2;
    logic lp_prev;
    logic wd_prev;
    logic [3:0] osc_div;
    logic [5:0] ext_cnt;
    logic ext_active;
    logic [5:0] bod_cnt;
    logic bod_active;
    logic [6:0] sample_win;
    logic sample_trip;
    logic [1:0] wd_cnt;
    logic [2:0] level;
    logic monitor_enable;
    logic [2:0] monitor_threshold;
    rsc_seq_type seq;
    logic [16:0] lp_cnt;
    logic [4:0] sys_cnt;
    logic sys_reset;
    logic [5:0] cause;
    logic soft_req;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsc_state_type;
endpackage : rsc_pkg

// [design/rsc_reset_controller.sv]
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_reset_controller #(
  parameter int unsigned LONG_TICKS = `RSC_LONG_TICKS
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire rsc_pkg::rsc_pins_type pins,
  input wire logic ccp_unlock,
  output logic sys_reset,
  output logic cpu_stall,
  output logic monitor_enable,
  output logic [2:0] monitor_threshold,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rsc_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Returns {hit, is_ctrl}
  function automatic logic [1:0] reg_sel(input logic [11:0] addr);
    logic [1:0] r;
    r = 2'h0;
    if (addr[11:10] == 2'h0 && addr[1:0] == 2'h0) begin
      if (addr[9:2] == `RSC_CAUSE_IDX) begin
        r = 2'h2;
      end else if (addr[9:2] == `RSC_CTRL_IDX) begin
        r = 2'h3;
      end
    end
    return r;
  endfunction : reg_sel

  rsc_state_type st;
  rsc_state_type next_st;
  logic lp_rise;
  logic osc_tick;
  logic any_src;
  logic [1:0] mode;
  logic forced;
  logic cont_mode;
  logic sampled_mode;
  logic [1:0] wsel;
  logic [1:0] rsel;
  logic do_write;
  logic soft_accept;

  always_comb begin
    lp_rise = st.sync2.lp_tick & ~st.lp_prev;
    osc_tick = st.osc_div == 4'(`RSC_OSC_DIV - 1);
    any_src = st.ext_active | st.bod_active | (st.wd_cnt != 2'h0) |
              st.sync2.debug_reset_req | st.soft_req;
    // R10 fuse per sleep state
    mode = st.sync2.deep_sleep ? st.sync2.monitor_sleep_mode_fuse :
           st.sync2.monitor_active_mode_fuse;
    // R2 forced on when off
    forced = (mode == `RSC_MODE_DISABLED || mode == `RSC_MODE_RESERVED) &&
             (st.sync2.chip_erase | st.sync2.debug_enable);
    // R11 mode decode
    cont_mode = forced | st.sample_trip | (mode == `RSC_MODE_ENABLED);
    sampled_mode = ~cont_mode & (mode == `RSC_MODE_SAMPLED);
    wsel = reg_sel(st.aw_addr);
    rsel = reg_sel(s_axi_araddr);
    do_write = st.aw_got & st.w_got & ~st.bvalid;
    // R20 protection gate
    soft_accept = do_write && wsel == 2'h3 && st.wstrb0 &&
                  st.wdata[`RSC_SOFT_BIT] && ccp_unlock;
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_st = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.lp_prev = st.sync2.lp_tick;
    next_st.wd_prev = st.sync2.watchdog_req;
    next_st.osc_div = osc_tick ? 4'h0 : st.osc_div + 4'h1;

    // R7 level frozen while programming
    if (!st.sync2.programming_mode) begin
      next_st.level = st.sync2.monitor_threshold_fuse;
    end
    // R6 code 111 is lowest level
    next_st.monitor_threshold = forced ? `RSC_LEVEL_LOWEST : st.level;

    // R12 pin held low past pulse time
    if (!st.sync2.ext_reset_b) begin
      if (st.ext_cnt <= 6'(`RSC_EXT_MIN_CYC)) begin
        next_st.ext_cnt = st.ext_cnt + 6'h1;
      end
      next_st.ext_active = st.ext_cnt >= 6'(`RSC_EXT_MIN_CYC);
    end else begin
      next_st.ext_cnt = 6'h0;
      next_st.ext_active = 1'b0;
    end

    // R8 sample window per tick
    if (sampled_mode && lp_rise) begin
      next_st.sample_win = 7'(`RSC_SAMPLE_WIN_CYC);
    end else if (!sampled_mode) begin
      next_st.sample_win = 7'h0;
    end else if (st.sample_win != 7'h0) begin
      next_st.sample_win = st.sample_win - 7'h1;
    end
    next_st.monitor_enable = cont_mode |
                             (sampled_mode & (next_st.sample_win != 7'h0));

    // R5 persistence filter
    if (st.monitor_enable && st.sync2.monitor_low) begin
      if (st.bod_cnt <= 6'(`RSC_BOD_MIN_CYC)) begin
        next_st.bod_cnt = st.bod_cnt + 6'h1;
      end
      if (st.bod_cnt >= 6'(`RSC_BOD_MIN_CYC)) begin
        // R3 brownout asserted at once
        next_st.bod_active = 1'b1;
        // R9 trip forces continuous
        next_st.sample_trip = st.sample_trip | sampled_mode;
        // Keep monitor powered across the switch
        next_st.monitor_enable = 1'b1;
      end
    end else begin
      next_st.bod_cnt = 6'h0;
      if (st.monitor_enable || !(cont_mode || sampled_mode)) begin
        next_st.bod_active = 1'b0;
        next_st.sample_trip = 1'b0;
      end
    end

    // R13 stretch over oscillator ticks
    if (st.sync2.watchdog_req && !st.wd_prev) begin
      next_st.wd_cnt = 2'h2;
    end else if (osc_tick && st.wd_cnt != 2'h0) begin
      next_st.wd_cnt = st.wd_cnt - 2'h1;
    end

    // R25 merged reset from all sources
    if (any_src) begin
      // R22 restart sequence
      next_st.seq = SEQ_HOLD;
      next_st.sys_reset = 1'b1;
      next_st.sys_cnt = 5'h0;
    end else begin
      case (st.seq)
        SEQ_HOLD: begin
          // R23 delay code select
          case (st.sync2.startup_delay_fuse)
            `RSC_DELAY_LONG: begin
              next_st.seq = SEQ_LP_WAIT;
              next_st.lp_cnt = 17'(LONG_TICKS);
            end
            `RSC_DELAY_SHORT: begin
              next_st.seq = SEQ_LP_WAIT;
              next_st.lp_cnt = 17'(`RSC_SHORT_TICKS);
            end
            default: begin
              next_st.seq = SEQ_SYS_WAIT;
              next_st.sys_cnt = 5'(`RSC_SYS_DELAY_CYC);
            end
          endcase
          // Fuses still crossing the synchroniser
          if (st.sys_cnt != 5'h0) begin
            next_st.seq = SEQ_HOLD;
            next_st.sys_cnt = st.sys_cnt - 5'h1;
          end
        end
        SEQ_LP_WAIT: begin
          if (lp_rise) begin
            next_st.lp_cnt = st.lp_cnt - 17'h1;
            if (st.lp_cnt <= 17'h1) begin
              next_st.seq = SEQ_SYS_WAIT;
              next_st.sys_cnt = 5'(`RSC_SYS_DELAY_CYC);
            end
          end
        end
        SEQ_SYS_WAIT: begin
          next_st.sys_cnt = st.sys_cnt - 5'h1;
          if (st.sys_cnt <= 5'h1) begin
            // R4 release only via counter
            next_st.seq = SEQ_RUN;
            next_st.sys_reset = 1'b0;
          end
        end
        SEQ_RUN: begin
          next_st.sys_reset = 1'b0;
        end
        default: begin
          next_st.seq = SEQ_HOLD;
          next_st.sys_reset = 1'b1;
        end
      endcase
    end

    // R19 self-clear on issue
    if (st.soft_req) begin
      next_st.soft_req = 1'b0;
    end else if (soft_accept) begin
      // R14 issued next cycle
      next_st.soft_req = 1'b1;
    end

    // AXI write channel capture
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wsel[1] ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = ~next_st.aw_got & ~next_st.bvalid;
    next_st.wready = ~next_st.w_got & ~next_st.bvalid;

    // R17 sticky flags, set wins over clear
    // R24 only power-on reset or a write of one clears them
    if (do_write && wsel == 2'h2 && st.wstrb0) begin
      next_st.cause = st.cause & ~st.wdata[5:0];
    end
    // R16 debug reset from debug port only
    next_st.cause[`RSC_FLAG_DEBUG] = next_st.cause[`RSC_FLAG_DEBUG] |
                                     st.sync2.debug_reset_req;
    next_st.cause[`RSC_FLAG_SOFT] = next_st.cause[`RSC_FLAG_SOFT] |
                                    st.soft_req;
    next_st.cause[`RSC_FLAG_WD] = next_st.cause[`RSC_FLAG_WD] |
                                  (st.wd_cnt != 2'h0);
    next_st.cause[`RSC_FLAG_BROWN] = next_st.cause[`RSC_FLAG_BROWN] |
                                     st.bod_active;
    next_st.cause[`RSC_FLAG_PIN] = next_st.cause[`RSC_FLAG_PIN] |
                                   st.ext_active;

    // AXI read channel
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = rsel[1] ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      case (rsel)
        2'h2: next_st.rdata = {26'h0, st.cause};
        2'h3: next_st.rdata = {31'h0, st.soft_req};
        default: next_st.rdata = 32'h0;
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.sync1.ext_reset_b <= 1'b1;
      st.sync2.ext_reset_b <= 1'b1;
      // R1 power-on holds reset
      st.seq <= SEQ_HOLD;
      st.sys_reset <= 1'b1;
      st.sys_cnt <= `RSC_SYNC_CYC;
      // R18 power-on flag set
      st.cause <= `RSC_CAUSE_RESET;
      st.level <= `RSC_LEVEL_LOWEST;
      st.monitor_threshold <= `RSC_LEVEL_LOWEST;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sys_reset = st.sys_reset;
  // R15 stall while request pending
  assign cpu_stall = st.soft_req;
  assign monitor_enable = st.monitor_enable;
  assign monitor_threshold = st.monitor_threshold;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_soft_issue;
    @(posedge mclk) disable iff (!rst_b)
    soft_accept |-> ##[1:2] sys_reset;
  endproperty
  a_soft_issue: assert property (p_soft_issue) // R14
    else $error("software reset not issued in two clocks");

  property p_stall;
    @(posedge mclk) disable iff (!rst_b)
    soft_accept |=> cpu_stall ##1 sys_reset;
  endproperty
  a_stall: assert property (p_stall) // R15
    else $error("no stall before software reset");

  // Length of the running watchdog request
  logic [4:0] wd_run;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wd_run <= 5'h0;
    end else if (st.wd_cnt == 2'h0) begin
      wd_run <= 5'h0;
    end else if (wd_run != 5'h1F) begin
      wd_run <= wd_run + 5'h1;
    end
  end

  property p_wd_len;
    @(posedge mclk) disable iff (!rst_b)
    $fell(st.wd_cnt != 2'h0) |-> wd_run >= 5'(`RSC_OSC_DIV) &&
                                 wd_run <= 5'(2 * `RSC_OSC_DIV);
  endproperty
  a_wd_len: assert property (p_wd_len) // R13
    else $error("watchdog reset not one to two periods long");

  property p_merge;
    @(posedge mclk) disable iff (!rst_b)
    any_src |=> sys_reset && st.seq == SEQ_HOLD;
  endproperty
  a_merge: assert property (p_merge) // R25
    else $error("reset released with source active");

  property p_release;
    @(posedge mclk) disable iff (!rst_b)
    $fell(sys_reset) |-> $past(st.seq) == SEQ_SYS_WAIT &&
                         $past(st.sys_cnt) == 5'h1;
  endproperty
  a_release: assert property (p_release) // R4
    else $error("reset released outside the counter");

  property p_forced;
    @(posedge mclk) disable iff (!rst_b)
    forced |=> monitor_enable && monitor_threshold == `RSC_LEVEL_LOWEST;
  endproperty
  a_forced: assert property (p_forced) // R2
    else $error("disabled monitor not forced to lowest level");

  property p_protect;
    @(posedge mclk) disable iff (!rst_b)
    do_write && wsel == 2'h3 && !ccp_unlock && !st.soft_req |=> !st.soft_req;
  endproperty
  a_protect: assert property (p_protect) // R20
    else $error("unprotected control write accepted");

  property p_pin_hold;
    @(posedge mclk) disable iff (!rst_b)
    st.ext_active && !st.sync2.ext_reset_b |=> sys_reset [*2];
  endproperty
  a_pin_hold: assert property (p_pin_hold) // R12
    else $error("reset dropped while pin low");

  property p_pon_clear;
    @(posedge mclk) disable iff (!rst_b)
    do_write && wsel == 2'h2 && st.wstrb0 && st.wdata[0] |=>
      !st.cause[`RSC_FLAG_PON];
  endproperty
  a_pon_clear: assert property (p_pon_clear) // R18
    else $error("power-on flag not cleared by write one");
endmodule : rsc_reset_controller

// [verification/rsc_far_side.sv]
`timescale 1ns/1ps
module rsc_far_side #(
  parameter int TICK_CYC = 60
) (
  input wire logic mclk,
  input wire logic pin_low,
  input wire logic supply_low,
  input wire logic monitor_enable,
  output logic ext_reset_b,
  output logic monitor_low,
  output logic lp_tick
);
  int cnt = 0;
  logic pat = 1'b0;
  // ==========
  // Slow tick and idle patterns
  always @(posedge mclk) begin
    cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
    lp_tick <= (cnt < TICK_CYC / 2);
    pat <= ~pat;
  end
  assign ext_reset_b = pin_low ? 1'b0 : 1'b1;
  // Unpowered monitor output is junk
  assign monitor_low = monitor_enable ? supply_low : pat;
endmodule : rsc_far_side

// [verification/tb_rsc_reset_controller.sv]
`timescale 1ns/1ps
`include "rsc_defs.svh"
module tb_rsc_reset_controller;
  import rsc_pkg::*;
  localparam int TK = 60;
  localparam logic [11:0] CAUSE = 12'h000;
  localparam logic [11:0] CTRL = 12'h004;
  logic mclk = 1'b0, rst_b = 1'b0, ccp = 1'b0, pl = 1'b0, sl = 1'b0;
  rsc_pins_type cfg, pins;
  logic sys_reset, cpu_stall, mon_en, ext_b, mlow, tick, sr_q;
  logic [2:0] mon_th;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int fails = 0, comparisons = 0, cyc = 0, stall_t = 0, rise_t = 0;

  always #25 mclk = ~mclk;
  always_comb begin
    pins = cfg;
    pins.ext_reset_b = ext_b;
    pins.monitor_low = mlow;
    pins.lp_tick = tick;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    sr_q <= sys_reset;
    if (cpu_stall) stall_t <= cyc;
    if (sys_reset && !sr_q) rise_t <= cyc;
  end

  rsc_reset_controller #(.LONG_TICKS(8)) uut (.mclk(mclk), .rst_b(rst_b),
    .pins(pins), .ccp_unlock(ccp), .sys_reset(sys_reset),
    .cpu_stall(cpu_stall), .monitor_enable(mon_en),
    .monitor_threshold(mon_th), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  rsc_far_side #(.TICK_CYC(TK)) far (.mclk(mclk), .pin_low(pl),
    .supply_low(sl), .monitor_enable(mon_en), .ext_reset_b(ext_b),
    .monitor_low(mlow), .lp_tick(tick));

  // ==========
  // Bus and check tasks
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    logic [1:0] br;
    int n;
    n = 0;
    bh = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh && n < 100) begin
      @(negedge mclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      br = bresp;
      @(posedge mclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!bh) fails++;
    chk("bresp", br, `RSC_RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, h;
    int n;
    n = 0;
    h = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!h && n < 100) begin
      @(negedge mclk);
      ta = arvalid && arready;
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!h) fails++;
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", r, `RSC_RESP_OKAY);
  endtask : rc

  task automatic rel(output int n);
    n = 0;
    while (sys_reset === 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
  endtask : rel

  task automatic pin(input int k, output logic hi);
    @(posedge mclk);
    pl <= 1'b1;
    repeat (k) @(posedge mclk);
    @(negedge mclk);
    hi = sys_reset;
    @(posedge mclk);
    pl <= 1'b0;
  endtask : pin

  task automatic settle(input int k);
    repeat (k) @(negedge mclk);
  endtask : settle

  // ==========
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(negedge mclk);
    chk("por hold", sys_reset, 1'b1);
    rel(n);
    chk("por delay", n >= 24 && n <= 40, 1'b1);
    rc(CAUSE, 32'h01);
    rc(CTRL, 32'h00);
    wr(CAUSE, 8'h01);
    rc(CAUSE, 32'h00);
    rd(12'h008, d, r);
    chk("unmapped", r, `RSC_RESP_SLVERR);
  endtask : t_regs

  task automatic t_pin;
    logic h;
    int n;
    pin(10, h);
    settle(3);
    chk("short pin", h | sys_reset, 1'b0);
    pin(40, h);
    chk("pin held", h, 1'b1);
    rel(n);
    chk("pin delay", n >= 24 && n <= 40, 1'b1);
    rc(CAUSE, 32'h02);
    wr(CAUSE, 8'h3F);
    rc(CAUSE, 32'h00);
    cfg.startup_delay_fuse <= `RSC_DELAY_LONG;
    pin(40, h);
    settle(100);
    pin(40, h);
    rel(n);
    chk("restart", n >= 7 * TK + 24 && n <= 9 * TK + 40, 1'b1);
    cfg.startup_delay_fuse <= `RSC_DELAY_SYS_ONLY;
    wr(CAUSE, 8'h3F);
  endtask : t_pin

  task automatic t_src;
    int n;
    cfg.watchdog_req <= 1'b1;
    settle(3);
    cfg.watchdog_req <= 1'b0;
    n = 0;
    while (sys_reset !== 1'b1 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    rel(n);
    chk("wd length", n >= 33 && n <= 50, 1'b1);
    rc(CAUSE, 32'h08);
    wr(CAUSE, 8'h3F);
    cfg.debug_reset_req <= 1'b1;
    settle(5);
    chk("dbg reset", sys_reset, 1'b1);
    cfg.debug_reset_req <= 1'b0;
    rel(n);
    rc(CAUSE, 32'h10);
    wr(CAUSE, 8'h3F);
  endtask : t_src

  task automatic t_soft;
    int c0, n;
    wr(CTRL, 8'h01);
    settle(5);
    chk("locked", sys_reset, 1'b0);
    rc(CTRL, 32'h00);
    c0 = cyc;
    ccp <= 1'b1;
    wr(CTRL, 8'h01);
    ccp <= 1'b0;
    settle(2);
    chk("stall", stall_t > c0 && rise_t - stall_t inside {1, 2},
        1'b1);
    rel(n);
    rc(CTRL, 32'h00);
    rc(CAUSE, 32'h20);
    wr(CAUSE, 8'h3F);
  endtask : t_soft

  task automatic t_mon;
    int n, k;
    cfg.monitor_threshold_fuse <= 3'h5;
    for (int i = 0; i < 4; i++) begin
      cfg.monitor_active_mode_fuse <= 2'(i);
      settle(5);
      if (i != 1) chk("mode", mon_en, 1'(i == 2));
    end
    cfg.monitor_active_mode_fuse <= `RSC_MODE_SAMPLED;
    k = 0;
    for (int i = 0; i < 2 * TK; i++) begin
      @(negedge mclk);
      k += int'(mon_en === 1'b1);
    end
    chk("sampled", k >= 22 && k <= 66, 1'b1);
    sl <= 1'b1;
    settle(2 * TK);
    chk("trip", {sys_reset, mon_en}, 2'h3);
    sl <= 1'b0;
    rel(n);
    chk("trip delay", n >= 24 && n <= 40, 1'b1);
    cfg.monitor_active_mode_fuse <= `RSC_MODE_ENABLED;
    settle(5);
    chk("level", mon_th, 3'h5);
    cfg.programming_mode <= 1'b1;
    cfg.monitor_threshold_fuse <= `RSC_LEVEL_HIGHEST;
    settle(5);
    chk("level kept", mon_th, 3'h5);
    cfg.programming_mode <= 1'b0;
    settle(5);
    chk("level new", mon_th, `RSC_LEVEL_HIGHEST);
    sl <= 1'b1;
    settle(10);
    sl <= 1'b0;
    settle(3);
    chk("short dip", sys_reset, 1'b0);
    sl <= 1'b1;
    settle(30);
    chk("brownout", sys_reset, 1'b1);
    sl <= 1'b0;
    rel(n);
    chk("bod delay", n >= 24 && n <= 40, 1'b1);
    rc(CAUSE, 32'h04);
    cfg.monitor_active_mode_fuse <= `RSC_MODE_DISABLED;
    cfg.debug_enable <= 1'b1;
    settle(5);
    chk("forced dbg", {mon_en, mon_th}, 4'hF);
    cfg.debug_enable <= 1'b0;
    cfg.chip_erase <= 1'b1;
    settle(5);
    chk("forced erase", {mon_en, mon_th}, 4'hF);
    cfg.chip_erase <= 1'b0;
    cfg.deep_sleep <= 1'b1;
    cfg.monitor_sleep_mode_fuse <= `RSC_MODE_ENABLED;
    settle(5);
    chk("sleep fuse", mon_en, 1'b1);
    cfg.deep_sleep <= 1'b0;
    settle(5);
    chk("active fuse", mon_en, 1'b0);
  endtask : t_mon

  task automatic wrap_up;
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  initial begin
    cfg = '0;
    cfg.startup_delay_fuse = `RSC_DELAY_SYS_ONLY;
    cfg.monitor_active_mode_fuse = `RSC_MODE_DISABLED;
    cfg.monitor_sleep_mode_fuse = `RSC_MODE_DISABLED;
    cfg.monitor_threshold_fuse = `RSC_LEVEL_LOWEST;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_pin();
    t_src();
    t_soft();
    t_mon();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up();
  end
endmodule : tb_rsc_reset_controller
